// ---- design/tpl_test_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpl_test_pins
    import tpl_pkg::*;
#(
    parameter int LP_EXIT_CYCLES = LP_EXIT_CYC
) (
    // Clocks and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              test_clock,
    // Configuration straps
    input  wire logic              flexible_mode,
    input  wire logic              trst_reserved,
    input  wire logic              probe_fuse_blown,
    // Low-power control
    input  wire logic              low_power_pin,
    output logic                   core_enable,
    output logic                   sleep_active,
    // Shared scan pins
    input  wire logic              tms,
    input  wire logic [NPINS-1:0]  pin_in,
    output logic      [NPINS-1:0]  pin_out,
    output logic      [NPINS-1:0]  pin_oe,
    output logic                   trst_pullup_en,
    // Core side of shared scan pins
    input  wire logic [NPINS-1:0]  user_out,
    input  wire logic [NPINS-1:0]  user_oe,
    output logic      [NPINS-1:0]  user_in,
    output logic                   test_active,
    // Probe pins
    input  wire logic              probe_a_in,
    output logic                   probe_out_a,
    output logic                   probe_a_oe,
    input  wire logic              probe_b_in,
    output logic                   probe_out_b,
    output logic                   probe_b_oe,
    // Core side of probe pins
    input  wire logic [NODE_W-1:0] probe_nodes,
    input  wire logic [SEL_W-1:0]  probe_sel_a,
    input  wire logic [SEL_W-1:0]  probe_sel_b,
    input  wire logic [NPROBE-1:0] probe_arm,
    input  wire logic [NPROBE-1:0] probe_user_out,
    input  wire logic [NPROBE-1:0] probe_user_oe,
    output logic      [NPROBE-1:0] probe_user_in
);

    localparam logic [LP_CNT_W-1:0] ENTRY_LAST = LP_CNT_W'(LP_ENTRY_CYC - LP_SYNC_CYC - 1);
    localparam logic [LP_CNT_W-1:0] EXIT_LAST  = LP_CNT_W'(LP_EXIT_CYCLES - LP_SYNC_CYC - 1);
    localparam logic [LP_CNT_W-1:0] ENTRY_DLY  = LP_CNT_W'(LP_ENTRY_CYC - LP_SYNC_CYC + 1);
    localparam logic [LP_CNT_W-1:0] EXIT_DLY   = LP_CNT_W'(LP_EXIT_CYCLES - LP_SYNC_CYC + 1);
    localparam logic [CHK_CNT_W-1:0] CHK_LAST  = CHK_CNT_W'(CHK_W);

    // Core-domain state
    logic [SYNC_W-1:0]   in_m_q;
    logic [SYNC_W-1:0]   in_s_q;
    tpl_lp_state_type    lp_state_q;
    logic [LP_CNT_W-1:0] lp_cnt_q;
    logic                lp_s;
    logic                lp_off;
    logic                tmode_m_q;
    logic                tmode_s_q;
    logic [NPROBE-1:0]   probe_q;
    logic [NPROBE-1:0]   probe_on_q;
    logic                lp_prev_q;
    logic [LP_CNT_W-1:0] lvl_cnt_q;

    // Scan-domain state
    logic                tap_rst_n;
    logic                flex_m_q;
    logic                flex_q;
    logic                test_mode_q;
    logic [CHK_CNT_W-1:0] chk_cnt_q;
    logic [CHK_W-1:0]    chk_acc_q;
    logic                chk_busy;
    logic                bypass_q;
    logic                tdo_q;
    logic                tdo_en_q;
    logic                tdo_own;
    logic                tdi;

    tpl_tap_if tap_bus ();

    // Probe node picker
    function automatic logic pick_node(input logic [NODE_W-1:0] nodes,
                                       input logic [SEL_W-1:0]  sel);
        pick_node = nodes[sel];
    endfunction : pick_node

    // Scan reset: pin acts only when reserved for it
    assign tap_rst_n      = rst_n & (~trst_reserved | pin_in[PIN_TRST]);
    assign trst_pullup_en = trst_reserved;
    assign tdi            = pin_in[PIN_TDI];

    tpl_tap_ctrl u_tap (
        .test_clock (test_clock),
        .tap_rst_n  (tap_rst_n),
        .tms        (tms),
        .tdi        (tdi),
        .tap        (tap_bus.tap)
    );

    //------------------------------------------------------------------
    // Scan clock domain
    //------------------------------------------------------------------

    // Mode strap into scan domain
    always_ff @(posedge test_clock or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            flex_m_q <= 1'b1;
            flex_q   <= 1'b1;
        end else begin
            flex_m_q <= flexible_mode;
            flex_q   <= flex_m_q;
        end
    end

    // Ownership of shared scan pins
    always_ff @(posedge test_clock or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            test_mode_q <= 1'b0;
        end else if (!flex_q) begin
            test_mode_q <= 1'b1;
        end else if (!tms) begin
            test_mode_q <= 1'b1;
        end else if (tap_bus.state == TAP_RESET) begin
            test_mode_q <= 1'b0;
        end
    end

    // Checksum runs once per instruction load
    assign chk_busy = (tap_bus.ir == IR_CHECKSUM) && (tap_bus.state == TAP_IDLE)
                      && (chk_cnt_q != CHK_LAST);

    // Checksum counter and accumulator
    always_ff @(posedge test_clock or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            chk_cnt_q <= '0;
            chk_acc_q <= '0;
        end else begin
            if (tap_bus.state == TAP_IR_UPD) begin
                chk_cnt_q <= '0;
            end else if (chk_busy) begin
                chk_cnt_q <= chk_cnt_q + 1'b1;
            end
            if (chk_busy) begin
                chk_acc_q <= {chk_acc_q[CHK_W-2:0], chk_acc_q[CHK_W-1]};
            end else if (tap_bus.state == TAP_DR_SH) begin
                chk_acc_q <= {chk_acc_q[CHK_W-2:0], chk_acc_q[CHK_W-1] ^ tdi};
            end
        end
    end

    // Bypass stage
    always_ff @(posedge test_clock or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            bypass_q <= 1'b0;
        end else if (tap_bus.state == TAP_DR_CAP) begin
            bypass_q <= 1'b0;
        end else if (tap_bus.state == TAP_DR_SH) begin
            bypass_q <= tdi;
        end
    end

    // Serial data out and its drive enable
    always_ff @(posedge test_clock or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tdo_q    <= 1'b0;
            tdo_en_q <= 1'b0;
        end else if (chk_busy) begin
            tdo_q    <= chk_acc_q[CHK_W-1];
            tdo_en_q <= 1'b1;
        end else if (tap_bus.state == TAP_IR_SH) begin
            tdo_q    <= tap_bus.ir_lsb;
            tdo_en_q <= 1'b1;
        end else if (tap_bus.state == TAP_DR_SH) begin
            tdo_q    <= (tap_bus.ir == IR_BYPASS) ? bypass_q : chk_acc_q[CHK_W-1];
            tdo_en_q <= 1'b1;
        end else begin
            tdo_q    <= 1'b0;
            tdo_en_q <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // Core clock domain
    //------------------------------------------------------------------

    // Pin input synchroniser
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            in_m_q <= '0;
            in_s_q <= '0;
        end else begin
            in_m_q <= {probe_fuse_blown, low_power_pin, probe_b_in, probe_a_in, pin_in};
            in_s_q <= in_m_q;
        end
    end

    assign lp_s = in_s_q[SY_LP];

    // Scan ownership into core domain
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tmode_m_q <= 1'b0;
            tmode_s_q <= 1'b0;
        end else begin
            tmode_m_q <= test_mode_q;
            tmode_s_q <= tmode_m_q;
        end
    end

    // Low-power sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lp_state_q <= LP_RUN;
            lp_cnt_q   <= '0;
        end else begin
            unique case (lp_state_q)
                LP_RUN: begin
                    lp_cnt_q <= '0;
                    if (lp_s) begin
                        lp_state_q <= LP_ENTER;
                    end
                end
                LP_ENTER: begin
                    lp_cnt_q <= lp_cnt_q + 1'b1;
                    if (!lp_s) begin
                        lp_state_q <= LP_WAKE;
                        lp_cnt_q   <= '0;
                    end else if (lp_cnt_q == ENTRY_LAST) begin
                        lp_state_q <= LP_SLEEP;
                    end
                end
                LP_SLEEP: begin
                    lp_cnt_q <= '0;
                    if (!lp_s) begin
                        lp_state_q <= LP_WAKE;
                    end
                end
                LP_WAKE: begin
                    lp_cnt_q <= lp_cnt_q + 1'b1;
                    if (lp_s) begin
                        lp_state_q <= LP_ENTER;
                        lp_cnt_q   <= '0;
                    end else if (lp_cnt_q == EXIT_LAST) begin
                        lp_state_q <= LP_RUN;
                    end
                end
            endcase
        end
    end

    // Core and input buffers off outside normal operation
    assign lp_off       = (lp_state_q != LP_RUN);
    assign core_enable  = ~lp_off;
    assign sleep_active = (lp_state_q == LP_SLEEP);
    assign test_active  = tmode_s_q;
    assign user_in       = lp_off ? '0 : in_s_q[NPINS-1:0];
    assign probe_user_in = lp_off ? '0 : in_s_q[SY_PROBEB:SY_PROBEA];

    // Probe capture of selected nodes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            probe_q    <= '0;
            probe_on_q <= '0;
        end else begin
            probe_q[0] <= pick_node(probe_nodes, probe_sel_a);
            probe_q[1] <= pick_node(probe_nodes, probe_sel_b);
            probe_on_q <= probe_arm & {NPROBE{~in_s_q[SY_FUSE]}};
        end
    end

    // Probe pins: probe output or plain user I/O
    assign probe_out_a = probe_on_q[0] ? probe_q[0] : probe_user_out[0];
    assign probe_out_b = probe_on_q[1] ? probe_q[1] : probe_user_out[1];
    assign probe_a_oe  = ~lp_off & (probe_on_q[0] | probe_user_oe[0]);
    assign probe_b_oe  = ~lp_off & (probe_on_q[1] | probe_user_oe[1]);

    // Shared scan pin multiplexer
    assign tdo_own = test_mode_q | tdo_en_q;
    always_comb begin
        pin_out = user_out;
        pin_oe  = user_oe;
        if (test_mode_q) begin
            pin_oe[PIN_TCK] = 1'b0;
            pin_oe[PIN_TDI] = 1'b0;
        end
        if (tdo_own) begin
            pin_out[PIN_TDO] = tdo_q;
            pin_oe[PIN_TDO]  = tdo_en_q;
        end
        if (trst_reserved) begin
            pin_oe[PIN_TRST] = 1'b0;
        end
        if (lp_off) begin
            pin_oe = '0;
        end
    end

    // Length of current low-power level, checker helper
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lp_prev_q <= 1'b0;
            lvl_cnt_q <= '0;
        end else begin
            lp_prev_q <= lp_s;
            if (lp_s != lp_prev_q) begin
                lvl_cnt_q <= LP_CNT_W'(1);
            end else if (lvl_cnt_q != '1) begin
                lvl_cnt_q <= lvl_cnt_q + 1'b1;
            end
        end
    end

    a_lp_tristate: assert property (@(posedge clock) disable iff (!rst_n)
        lp_off |-> (pin_oe == '0) && !probe_a_oe && !probe_b_oe && user_in == '0)
        else $error("pins not released in low power");

    a_lp_entry_time: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(sleep_active) |-> lp_s && lvl_cnt_q == ENTRY_DLY)
        else $error("low-power entry not at expected cycle");

    a_lp_exit_time: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(core_enable) |-> !lp_s && lvl_cnt_q == EXIT_DLY)
        else $error("wake-up not at expected cycle");

    a_scan_claim: assert property (@(posedge test_clock) disable iff (!tap_rst_n)
        (flex_q && !tms) |=> test_mode_q && !pin_oe[PIN_TCK] || lp_off)
        else $error("low mode-select did not claim scan pins");

    a_scan_hold: assert property (@(posedge test_clock) disable iff (!tap_rst_n)
        $fell(test_mode_q) |-> $past(tap_bus.state == TAP_RESET) && $past(tms))
        else $error("scan pins released outside reset state");

    a_dedicated_mode: assert property (@(posedge test_clock) disable iff (!tap_rst_n)
        !flex_q |=> test_mode_q)
        else $error("dedicated mode lost scan pins");

    sequence s_chk_run;
        chk_busy ##1 chk_busy;
    endsequence

    a_chk_drive: assert property (@(posedge test_clock) disable iff (!tap_rst_n)
        s_chk_run |-> tdo_en_q && tdo_own ##1 tdo_en_q)
        else $error("data-out not driven during checksum");

    a_probe_drive: assert property (@(posedge clock) disable iff (!rst_n)
        (probe_arm[0] && !in_s_q[SY_FUSE] && !lp_off) ##1 !lp_off
        |-> probe_a_oe && probe_out_a == $past(pick_node(probe_nodes, probe_sel_a), 1))
        else $error("probe A not following selected node");

    a_probe_fuse: assert property (@(posedge clock) disable iff (!rst_n)
        $past(in_s_q[SY_FUSE]) |-> probe_on_q == '0)
        else $error("probe active with fuse blown");

endmodule : tpl_test_pins
`default_nettype wire

// ---- design/tpl_pkg.sv ----
package tpl_pkg;

    // Core clock and low-power timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int LP_ENTRY_NS   = 800;
    localparam int LP_EXIT_US    = 200;
    localparam int NS_PER_US     = 1000;
    localparam int LP_ENTRY_CYC  = LP_ENTRY_NS / CLK_PERIOD_NS;
    localparam int LP_EXIT_CYC   = LP_EXIT_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int LP_SYNC_CYC   = 2;
    localparam int LP_CNT_W      = 14;

    // Scan controller
    localparam int              TMS_RESET_TCKS = 5;
    localparam int              IR_W           = 4;
    localparam logic [IR_W-1:0] IR_BYPASS      = 4'hf;
    localparam logic [IR_W-1:0] IR_CHECKSUM    = 4'h5;
    localparam logic [IR_W-1:0] IR_CAPTURE     = 4'h1;
    localparam int              CHK_W          = 16;
    localparam int              CHK_CNT_W      = 5;

    // Shared scan pins, index into pin vectors
    localparam int NPINS    = 4;
    localparam int PIN_TCK  = 0;
    localparam int PIN_TDI  = 1;
    localparam int PIN_TDO  = 2;
    localparam int PIN_TRST = 3;

    // Bits of the pin input synchroniser
    localparam int SYNC_W    = 8;
    localparam int SY_PROBEA = 4;
    localparam int SY_PROBEB = 5;
    localparam int SY_LP     = 6;
    localparam int SY_FUSE   = 7;

    // Probe node selection
    localparam int NODE_W = 16;
    localparam int SEL_W  = 4;
    localparam int NPROBE = 2;

    typedef enum logic [3:0] {
        TAP_RESET  = 4'h0, TAP_IDLE   = 4'h1, TAP_DR_SEL = 4'h2, TAP_DR_CAP = 4'h3,
        TAP_DR_SH  = 4'h4, TAP_DR_EX1 = 4'h5, TAP_DR_PAU = 4'h6, TAP_DR_EX2 = 4'h7,
        TAP_DR_UPD = 4'h8, TAP_IR_SEL = 4'h9, TAP_IR_CAP = 4'ha, TAP_IR_SH  = 4'hb,
        TAP_IR_EX1 = 4'hc, TAP_IR_PAU = 4'hd, TAP_IR_EX2 = 4'he, TAP_IR_UPD = 4'hf
    } tpl_tap_state_type;

    typedef enum logic [1:0] {
        LP_RUN   = 2'b00,
        LP_ENTER = 2'b01,
        LP_SLEEP = 2'b10,
        LP_WAKE  = 2'b11
    } tpl_lp_state_type;

endpackage : tpl_pkg

// ---- design/tpl_tap_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface tpl_tap_if;
    import tpl_pkg::*;
    tpl_tap_state_type state;
    logic [IR_W-1:0]   ir;
    logic              ir_lsb;

    modport tap  (output state, output ir, output ir_lsb);
    modport core (input state, input ir, input ir_lsb);
endinterface : tpl_tap_if
`default_nettype wire

// ---- design/tpl_tap_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpl_tap_ctrl
    import tpl_pkg::*;
(
    // Scan clock and reset
    input  wire logic test_clock,
    input  wire logic tap_rst_n,
    // Scan inputs
    input  wire logic tms,
    input  wire logic tdi,
    // Controller state out
    tpl_tap_if.tap    tap
);

    tpl_tap_state_type state_q;
    logic [IR_W-1:0]   ir_sh_q;
    logic [IR_W-1:0]   ir_q;

    // Standard controller state graph
    function automatic tpl_tap_state_type tap_next(input tpl_tap_state_type s,
                                                   input logic m);
        unique case (s)
            TAP_RESET:  tap_next = m ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   tap_next = m ? TAP_DR_SEL : TAP_IDLE;
            TAP_DR_SEL: tap_next = m ? TAP_IR_SEL : TAP_DR_CAP;
            TAP_DR_CAP: tap_next = m ? TAP_DR_EX1 : TAP_DR_SH;
            TAP_DR_SH:  tap_next = m ? TAP_DR_EX1 : TAP_DR_SH;
            TAP_DR_EX1: tap_next = m ? TAP_DR_UPD : TAP_DR_PAU;
            TAP_DR_PAU: tap_next = m ? TAP_DR_EX2 : TAP_DR_PAU;
            TAP_DR_EX2: tap_next = m ? TAP_DR_UPD : TAP_DR_SH;
            TAP_DR_UPD: tap_next = m ? TAP_DR_SEL : TAP_IDLE;
            TAP_IR_SEL: tap_next = m ? TAP_RESET  : TAP_IR_CAP;
            TAP_IR_CAP: tap_next = m ? TAP_IR_EX1 : TAP_IR_SH;
            TAP_IR_SH:  tap_next = m ? TAP_IR_EX1 : TAP_IR_SH;
            TAP_IR_EX1: tap_next = m ? TAP_IR_UPD : TAP_IR_PAU;
            TAP_IR_PAU: tap_next = m ? TAP_IR_EX2 : TAP_IR_PAU;
            TAP_IR_EX2: tap_next = m ? TAP_IR_UPD : TAP_IR_SH;
            TAP_IR_UPD: tap_next = m ? TAP_DR_SEL : TAP_IDLE;
        endcase
    endfunction : tap_next

    // State register, asynchronously initialised by scan reset
    always_ff @(posedge test_clock or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            state_q <= TAP_RESET;
        end else begin
            state_q <= tap_next(state_q, tms);
        end
    end

    // Instruction shift and update
    always_ff @(posedge test_clock or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_sh_q <= IR_CAPTURE;
            ir_q    <= IR_BYPASS;
        end else begin
            if (state_q == TAP_IR_CAP) begin
                ir_sh_q <= IR_CAPTURE;
            end else if (state_q == TAP_IR_SH) begin
                ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]};
            end
            if (state_q == TAP_RESET) begin
                ir_q <= IR_BYPASS;
            end else if (state_q == TAP_IR_UPD) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    assign tap.state  = state_q;
    assign tap.ir     = ir_q;
    assign tap.ir_lsb = ir_sh_q[0];

    sequence s_tms_high5;
        tms [*5];
    endsequence

    a_tms_five_reset: assert property (@(posedge test_clock) disable iff (!tap_rst_n)
        s_tms_high5 |=> state_q == TAP_RESET)
        else $error("five high mode-select cycles did not reach reset");

    a_trst_init: assert property (@(posedge test_clock)
        !tap_rst_n |-> state_q == TAP_RESET)
        else $error("scan reset did not initialise controller");

    a_tap_graph: assert property (@(posedge test_clock) disable iff (!tap_rst_n)
        (state_q == TAP_IR_SEL && tms) ##1 !tms |=> state_q == TAP_IDLE)
        else $error("controller left state graph");

endmodule : tpl_tap_ctrl
`default_nettype wire

// ---- bench/tpl_scan_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpl_scan_host (
    // Scan link
    output logic test_clock,
    output logic tms,
    output logic tdi
);
    // Clock parked low outside frames
    initial begin
        test_clock = 1'b0;
        tms        = 1'b1;
        tdi        = 1'b0;
    end
    // Frame of n bits, LSB first, changed while the clock is low
    task automatic frame(input logic [31:0] m, input logic [31:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            tms = m[i];
            tdi = d[i];
            #32 test_clock = 1'b1;
            #32 test_clock = 1'b0;
        end
        tdi = ~tdi; // Inverted data line
    endtask : frame
endmodule : tpl_scan_host
`default_nettype wire

// ---- bench/tpl_test_pins_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpl_test_pins_bench;
    import tpl_pkg::*;
    typedef struct {logic [2:0] v; int c;} tpl_ev_type;
    localparam int EXIT_CYC = 16;
    logic clock, rst_n, tck, tms, tdi, lp, fuse, trst_n, pa_in, pb_in, ce, sa, ta, pu;
    logic pa, pb, pa_oe, pb_oe, ea, eb, flex, trsv;
    logic [NPINS-1:0] pin_in, pin_out, pin_oe, user_out, user_oe, user_in;
    logic [NODE_W-1:0] nodes;
    logic [SEL_W-1:0] sel_a, sel_b;
    logic [NPROBE-1:0] arm, pu_out, pu_oe, pu_in;
    logic [2:0] last_ev;
    int bad_count, cmp_count, cyc, k, seed;
    tpl_ev_type evq[$];
    tpl_ev_type ev;

    tpl_scan_host host (.test_clock(tck), .tms(tms), .tdi(tdi));
    // Shared pins: clock, data in, data out, pulled-up scan reset
    assign pin_in = {trst_n, pin_oe[2] ? pin_out[2] : ~pin_out[2], tdi, tck};

    tpl_test_pins #(.LP_EXIT_CYCLES(EXIT_CYC)) DUT (
        .clock(clock), .rst_n(rst_n), .test_clock(tck), .flexible_mode(flex),
        .trst_reserved(trsv), .probe_fuse_blown(fuse), .low_power_pin(lp),
        .core_enable(ce), .sleep_active(sa), .tms(tms), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .trst_pullup_en(pu), .user_out(user_out),
        .user_oe(user_oe), .user_in(user_in), .test_active(ta), .probe_a_in(pa_in),
        .probe_out_a(pa), .probe_a_oe(pa_oe), .probe_b_in(pb_in), .probe_out_b(pb),
        .probe_b_oe(pb_oe), .probe_nodes(nodes), .probe_sel_a(sel_a),
        .probe_sel_b(sel_b), .probe_arm(arm), .probe_user_out(pu_out),
        .probe_user_oe(pu_oe), .probe_user_in(pu_in));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic note(input logic [2:0] v, input int c);
        evq.push_back('{v, c});
    endtask : note

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    // Core clock and cycle count
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) cyc <= cyc + 1;

    // Event watcher: oldest note against each change of power and test state
    always @(negedge clock) begin
        if (rst_n && {ce, sa, ta} !== last_ev) begin
            last_ev = {ce, sa, ta};
            if (evq.size() == 0) check("spurious event", last_ev, ~last_ev);
            else begin
                ev = evq.pop_front();
                check("event state", last_ev, ev.v);
                if (ev.c >= 0) check("event cycle", cyc, ev.c);
            end
        end
    end

    // Watchdog
    initial begin
        #300000;
        bad_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        {rst_n, lp, fuse, pa_in, pb_in, arm, pu_out, pu_oe, nodes, sel_a, sel_b} = '0;
        {trst_n, user_out, user_oe, bad_count, cmp_count} = '0;
        {trst_n, flex, trsv} = 3'h7;
        last_ev = 3'h4;
        seed = 5076;
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        // Probes follow the selected node one cycle late
        arm = 2'h3;
        user_out = $random(seed);
        for (int i = 0; i < 20; i++) begin
            @(negedge clock);
            if (i > 0) begin
                check("probe_out_a", pa, ea);
                check("probe_out_b", pb, eb);
                check("probe oe", {pb_oe, pa_oe}, 2'h3);
            end
            nodes = $random(seed);
            sel_a = $random(seed);
            sel_b = $random(seed);
            ea = nodes[sel_a];
            eb = nodes[sel_b];
        end
        {fuse, pu_oe, pu_out, pb_in} = 6'h2f;
        repeat (4) @(negedge clock);
        check("probe oe fused", {pb_oe, pa_oe}, 2'h1);
        check("probe_out_b fused", pb, 1'b1);
        check("probe user in", pu_in, 2'h2);
        $display("probe test done");
        // Scan ownership, checksum output, release, scan reset
        user_oe = 4'hf;
        note(3'h5, -1);
        host.frame(32'h306, 32'ha0, 14);
        check("scan pins owned", pin_oe[1:0], 2'h0);
        check("tdo checksum drive", pin_oe[2], 1'b1);
        host.frame(32'h0, 32'h0, 20);
        check("tdo after checksum", pin_oe[2], 1'b0);
        note(3'h4, -1);
        host.frame(32'h1f, 32'h0, 5);
        repeat (8) @(negedge clock);
        check("pins released", pin_oe, 4'h7);
        note(3'h5, -1);
        host.frame(32'h0, 32'h0, 1);
        repeat (8) @(negedge clock);
        note(3'h4, -1);
        trst_n = 1'b0;
        // Scan clock keeps running while the scan reset pin is low
        host.frame(32'h0, 32'h0, 3);
        @(negedge clock);
        trst_n = 1'b1;
        check("scan reset release", pin_oe, 4'h7);
        check("scan reset pull-up", pu, 1'b1);
        // Dedicated mode, reset pin as plain I/O held low
        note(3'h5, -1);
        {flex, trsv, trst_n} = 3'h0;
        host.frame(32'h7ce, 32'h0, 11);
        repeat (8) @(negedge clock);
        check("dedicated pins", pin_oe, 4'h8);
        check("reset pin pull-up off", pu, 1'b0);
        // Back to flexible mode, five high mode-select clocks release
        note(3'h4, -1);
        {flex, trsv, trst_n} = 3'h7;
        host.frame(32'h1f, 32'h0, 5);
        repeat (8) @(negedge clock);
        check("flexible pins released", pin_oe, 4'h7);
        check("pin_out released", pin_out, user_out);
        $display("scan test done");
        // Low-power entry and exit timing
        lp = 1'b1;
        k = cyc + 1;
        note(3'h0, k + 2);
        note(3'h2, k + LP_ENTRY_CYC);
        repeat (40) @(negedge clock);
        check("sleep pin oe", {pin_oe, pb_oe, pa_oe}, 6'h0);
        check("sleep user in", user_in, 4'h0);
        lp = 1'b0;
        k = cyc + 1;
        note(3'h0, k + 2);
        note(3'h4, k + EXIT_CYC);
        for (int i = 0; i < 100 && evq.size() != 0; i++) @(negedge clock);
        check("events left", evq.size(), 0);
        $display("low power test done");
        print_verdict();
    end
endmodule : tpl_test_pins_bench
`default_nettype wire
